// >>> host_reader.sv
// host model: byte reads of the telemetry registers
`timescale 1ns/1ps
module host_reader (
    input  wire logic       clk_in,
    output logic            stb_out,
    output logic [7:0]      addr_out,
    input  wire logic       valid_in,
    input  wire logic [7:0] data_in
);
    initial begin
        stb_out = 1'b0;
        addr_out = 8'h00;
    end
    // one strobe edge; answer is registered on that edge, so read it just after
    task automatic rd_byte(input logic [7:0] a, output logic [8:0] b);
        @(posedge clk_in);
        #1;
        stb_out = 1'b1;
        addr_out = a;
        @(posedge clk_in);
        #1;
        stb_out = 1'b0;
        // idle address flips so stale values never look like a request
        addr_out = ~a;
        b = {valid_in, data_in};
    endtask
    // high byte first, then low byte of the same register
    task automatic rd_word(input logic [7:0] a, output logic [15:0] w, output logic [1:0] v);
        logic [8:0] hi;
        logic [8:0] lo;
        rd_byte(a, hi);
        rd_byte(a, lo);
        w = {hi[7:0], lo[7:0]};
        v = {hi[8], lo[8]};
    endtask
endmodule

// >>> output_telemetry_readout.sv
// output telemetry readout: voltage, current and power registers read bytewise
// Overview of operation
// - voltage register holds 12-bit differential remote sense reading in bits 15:4.
// - voltage read as two bytes: high byte, then low nibble in top bits.
// - voltage code scales 378 uV per step, converter supplies the code.
// - current register holds 12-bit sense resistor drop in bits 15:4.
// - current read as two bytes: high byte, then low nibble in top bits.
// - current step follows range field bits 7:6 of configuration register.
// - power register holds 16-bit product of voltage and current readings.
// - power read as two bytes: high byte first, low byte second.
`timescale 1ns/1ps
`include "telemetry_params.svh"
module output_telemetry_readout
    import telemetry_pkg::*;
#(
    parameter int CODE_W = 12
) (
    input  wire logic              CLOCK_IN,
    input  wire logic              RESET_N_IN,
    input  wire logic [CODE_W-1:0] VOLT_CODE_IN,
    input  wire logic [CODE_W-1:0] CURR_CODE_IN,
    input  wire logic [7:0]        RANGE_CFG_IN,
    input  wire logic              RD_STB_IN,
    input  wire logic [7:0]        RD_ADDR_IN,
    output logic                   RD_VALID_OUT,
    output logic      [7:0]        RD_DATA_OUT,
    output logic      [1:0]        CURR_RANGE_OUT
);
    ////////////////////////////////////////////////////////////////////////
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sample_t     live_r;
    sample_t     live_nxt;
    logic [1:0]  range_r;
    logic [1:0]  range_nxt;
    logic [15:0] power_w;

    // converter codes are taken as given; 378 uV/step lives in the converter
    always_comb begin
        live_nxt.volt_code = VOLT_CODE_IN;
        live_nxt.curr_code = CURR_CODE_IN;
        range_nxt          = RANGE_CFG_IN[`RANGE_FIELD_HI:`RANGE_FIELD_LO];
    end

    always_ff @(posedge CLOCK_IN or negedge rst_n_r) begin
        if (!rst_n_r) begin
            live_r  <= '0;
            range_r <= `RANGE_LOW_SPAN;
        end else begin
            live_r  <= live_nxt;
            range_r <= range_nxt;
        end
    end

    // product lags the codes by one cycle
    power_product #(
        .CODE_W    (CODE_W)
    ) u_power (
        .clk_in    (CLOCK_IN),
        .rst_n_in  (rst_n_r),
        .volt_in   (live_r.volt_code),
        .curr_in   (live_r.curr_code),
        .power_out (power_w)
    );

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] word_volt;
    logic [15:0] word_curr;
    logic [15:0] snap_r;
    logic [15:0] snap_nxt;
    logic [7:0]  snap_addr_r;
    logic [7:0]  snap_addr_nxt;
    byte_phase_t phase_r;
    byte_phase_t phase_nxt;
    read_byte_t  out_r;
    read_byte_t  out_nxt;
    logic        mapped;
    logic [15:0] word_sel;

    always_comb begin
        word_volt = {live_r.volt_code, `RESERVED_NIBBLE};
        word_curr = {live_r.curr_code, `RESERVED_NIBBLE};
        mapped    = 1'b1;
        case (RD_ADDR_IN)
            `REG_ADDR_VOLT:  word_sel = word_volt;
            `REG_ADDR_CURR:  word_sel = word_curr;
            `REG_ADDR_POWER: word_sel = power_w;
            default: begin
                word_sel = 16'h0000;
                mapped   = 1'b0;
            end
        endcase
        snap_nxt      = snap_r;
        snap_addr_nxt = snap_addr_r;
        phase_nxt     = phase_r;
        out_nxt.valid = RD_STB_IN;
        out_nxt.data  = `READ_ZERO;
        if (RD_STB_IN) begin
            // low byte only from the snapshot when same register follows
            if (phase_r == BYTE_LOW && RD_ADDR_IN == snap_addr_r) begin
                out_nxt.data = snap_r[7:0];
                phase_nxt    = BYTE_HIGH;
            end else if (mapped) begin
                snap_nxt      = word_sel;
                snap_addr_nxt = RD_ADDR_IN;
                out_nxt.data  = word_sel[`READING_MSB -: 8];
                phase_nxt     = BYTE_LOW;
            end else begin
                phase_nxt = BYTE_HIGH;
            end
        end
    end

    always_ff @(posedge CLOCK_IN or negedge rst_n_r) begin
        if (!rst_n_r) begin
            snap_r      <= 16'h0000;
            snap_addr_r <= 8'h00;
            phase_r     <= BYTE_HIGH;
            out_r       <= '0;
        end else begin
            snap_r      <= snap_nxt;
            snap_addr_r <= snap_addr_nxt;
            phase_r     <= phase_nxt;
            out_r       <= out_nxt;
        end
    end

    assign RD_VALID_OUT   = out_r.valid;
    assign RD_DATA_OUT    = out_r.data;
    assign CURR_RANGE_OUT = range_r;

    ////////////////////////////////////////////////////////////////////////
    property p_volt_layout;
        @(posedge CLOCK_IN) disable iff (!rst_n_r)
        RD_STB_IN && RD_ADDR_IN == `REG_ADDR_VOLT && phase_r == BYTE_HIGH
        |=> RD_DATA_OUT == $past(live_r.volt_code[11:4]);
    endproperty
    a_volt_layout: assert property (p_volt_layout) else $error("voltage high byte wrong");

    // low nibble held from the code seen at the high-byte read, not from the snapshot register
    property p_volt_low;
        logic [3:0] n;
        @(posedge CLOCK_IN) disable iff (!rst_n_r)
        (RD_STB_IN && RD_ADDR_IN == `REG_ADDR_VOLT && phase_r == BYTE_HIGH, n = live_r.volt_code[3:0]) ##1
        RD_STB_IN && RD_ADDR_IN == `REG_ADDR_VOLT
        |=> RD_DATA_OUT == {n, `RESERVED_NIBBLE};
    endproperty
    a_volt_low: assert property (p_volt_low) else $error("voltage low byte wrong");

    property p_curr_high;
        @(posedge CLOCK_IN) disable iff (!rst_n_r)
        RD_STB_IN && RD_ADDR_IN == `REG_ADDR_CURR && phase_r == BYTE_HIGH
        |=> RD_DATA_OUT == $past(live_r.curr_code[11:4]);
    endproperty
    a_curr_high: assert property (p_curr_high) else $error("current high byte wrong");

    property p_curr_low;
        @(posedge CLOCK_IN) disable iff (!rst_n_r)
        RD_STB_IN && RD_ADDR_IN == `REG_ADDR_CURR && phase_r == BYTE_HIGH ##1
        RD_STB_IN && RD_ADDR_IN == `REG_ADDR_CURR
        |=> RD_DATA_OUT[3:0] == 4'h0;
    endproperty
    a_curr_low: assert property (p_curr_low) else $error("current reserved bits set");

    property p_range;
        @(posedge CLOCK_IN) disable iff (!rst_n_r)
        1'b1 |=> CURR_RANGE_OUT == $past(RANGE_CFG_IN[`RANGE_FIELD_HI:`RANGE_FIELD_LO]);
    endproperty
    a_range: assert property (p_range) else $error("range field not followed");

    property p_power;
        @(posedge CLOCK_IN) disable iff (!rst_n_r)
        1'b1 |=> power_w == 16'((24'($past(live_r.volt_code)) * 24'($past(live_r.curr_code))) >> 8);
    endproperty
    a_power: assert property (p_power) else $error("power product wrong");

    property p_power_pair;
        logic [15:0] w;
        @(posedge CLOCK_IN) disable iff (!rst_n_r)
        (RD_STB_IN && RD_ADDR_IN == `REG_ADDR_POWER && phase_r == BYTE_HIGH, w = power_w) ##1
        (RD_STB_IN && RD_ADDR_IN == `REG_ADDR_POWER)
        |=> RD_DATA_OUT == w[7:0] && $past(RD_DATA_OUT) == w[15:8];
    endproperty
    a_power_pair: assert property (p_power_pair) else $error("power bytes not paired");

    property p_snapshot;
        logic [15:0] w;
        @(posedge CLOCK_IN) disable iff (!rst_n_r)
        (RD_STB_IN && RD_ADDR_IN == `REG_ADDR_VOLT && phase_r == BYTE_HIGH, w = word_volt) ##1
        first_match(##[0:15] RD_STB_IN) ##0 RD_ADDR_IN == `REG_ADDR_VOLT
        |=> RD_DATA_OUT == w[7:0];
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("low byte from other sample");

    property p_valid;
        @(posedge CLOCK_IN) disable iff (!rst_n_r)
        RD_STB_IN |=> RD_VALID_OUT ##1 ($past(RD_STB_IN) == RD_VALID_OUT);
    endproperty
    a_valid: assert property (p_valid) else $error("read valid not one cycle after strobe");

    c_volt_pair: cover property (@(posedge CLOCK_IN) disable iff (!rst_n_r)
        RD_STB_IN && RD_ADDR_IN == `REG_ADDR_VOLT ##1 RD_STB_IN && RD_ADDR_IN == `REG_ADDR_VOLT);
    c_power_pair: cover property (@(posedge CLOCK_IN) disable iff (!rst_n_r)
        RD_STB_IN && RD_ADDR_IN == `REG_ADDR_POWER ##1 RD_STB_IN && RD_ADDR_IN == `REG_ADDR_POWER);
    c_range_change: cover property (@(posedge CLOCK_IN) disable iff (!rst_n_r)
        CURR_RANGE_OUT != $past(CURR_RANGE_OUT));
    c_snap_gap: cover property (@(posedge CLOCK_IN) disable iff (!rst_n_r)
        RD_STB_IN && RD_ADDR_IN == `REG_ADDR_VOLT ##1 !RD_STB_IN ##1 RD_STB_IN && RD_ADDR_IN == `REG_ADDR_VOLT);
    c_unmapped: cover property (@(posedge CLOCK_IN) disable iff (!rst_n_r)
        RD_STB_IN && !mapped);
endmodule

// >>> output_telemetry_readout_bench.sv
// self-checking bench for the output telemetry readout block
`timescale 1ns/1ps
module output_telemetry_readout_bench;
    import telemetry_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        stb;
    logic        valid;
    logic [11:0] volt;
    logic [11:0] curr;
    logic [7:0]  cfg;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic [1:0]  rng;
    logic [8:0]  b;
    int          fails = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    output_telemetry_readout uut (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .VOLT_CODE_IN(volt),
        .CURR_CODE_IN(curr), .RANGE_CFG_IN(cfg), .RD_STB_IN(stb), .RD_ADDR_IN(addr),
        .RD_VALID_OUT(valid), .RD_DATA_OUT(data), .CURR_RANGE_OUT(rng));
    host_reader host (.clk_in(clk), .stb_out(stb), .addr_out(addr), .valid_in(valid), .data_in(data));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic finish_test();
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // hang guard, far above the roughly 120 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            finish_test();
        end
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // power needs two cycles past the codes, so wait three
    task automatic set_codes(input logic [11:0] v, input logic [11:0] c);
        @(posedge clk);
        #1;
        volt = v;
        curr = c;
        repeat (3) @(posedge clk);
    endtask
    task automatic rd_chk(input string n, input logic [7:0] a, input logic [15:0] e);
        logic [15:0] w;
        logic [1:0]  v;
        host.rd_word(a, w, v);
        chk({n, " valid"}, 16'h0003, {14'h0000, v});
        chk(n, e, w);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_volt();
        logic [11:0] codes [3] = '{12'h000, 12'hF7C, 12'hA53};
        foreach (codes[i]) begin
            set_codes(codes[i], 12'h3D6);
            rd_chk("volt", 8'h17, {codes[i], 4'h0});
        end
    endtask
    task automatic t_curr();
        logic [11:0] codes [3] = '{12'h3D6, 12'h7AE, 12'hFFF};
        foreach (codes[i]) begin
            set_codes(12'hA53, codes[i]);
            rd_chk("curr", 8'h18, {codes[i], 4'h0});
        end
    endtask
    task automatic t_power();
        logic [11:0] vs [3] = '{12'hA53, 12'hFFF, 12'hF7C};
        logic [11:0] cs [3] = '{12'h3D6, 12'hFFF, 12'h001};
        logic [23:0] p;
        foreach (vs[i]) begin
            set_codes(vs[i], cs[i]);
            p = vs[i] * cs[i];
            rd_chk("power", 8'h19, p[23:8]);
        end
    endtask
    task automatic t_range();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            cfg = {i[1:0], 6'h15};
            @(posedge clk);
            #1;
            chk("range", {14'h0000, i[1:0]}, {14'h0000, rng});
        end
    endtask
    // code changes between the two bytes; low byte must stay with the first sample
    task automatic t_snap();
        set_codes(12'hA53, 12'h3D6);
        host.rd_byte(8'h17, b);
        chk("snap hi", 16'h01A5, {7'h00, b});
        set_codes(12'h5AC, 12'h3D6);
        host.rd_byte(8'h17, b);
        chk("snap lo", 16'h0130, {7'h00, b});
        host.rd_byte(8'h17, b);
        chk("third hi", 16'h015A, {7'h00, b});
    endtask
    // unmapped read gives zero; switching address restarts at the high byte
    task automatic t_unmapped();
        host.rd_byte(8'h20, b);
        chk("unmapped", 16'h0100, {7'h00, b});
        host.rd_byte(8'h17, b);
        host.rd_byte(8'h18, b);
        chk("restart hi", 16'h013D, {7'h00, b});
        host.rd_byte(8'h18, b);
        chk("restart lo", 16'h0160, {7'h00, b});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        volt = 12'h000;
        curr = 12'h000;
        cfg = 8'h00;
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (4) @(posedge clk);
        t_volt();
        t_curr();
        t_power();
        t_range();
        t_snap();
        t_unmapped();
        finish_test();
    end
endmodule

// >>> power_product.sv
// registered voltage-by-current product, top 16 bits kept
`timescale 1ns/1ps
module power_product
    import telemetry_pkg::*;
#(
    parameter int CODE_W = 12
) (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic [CODE_W-1:0] volt_in,
    input  wire logic [CODE_W-1:0] curr_in,
    output logic      [15:0]       power_out
);
    logic [2*CODE_W-1:0] prod;
    logic [15:0]         power_nxt;
    logic [15:0]         power_r;

    // keep the upper 16 bits of the full product so full scale fits
    always_comb begin
        prod      = volt_in * curr_in;
        power_nxt = prod[2*CODE_W-1 -: 16];
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            power_r <= 16'h0000;
        end else begin
            power_r <= power_nxt;
        end
    end

    assign power_out = power_r;
endmodule

// >>> telemetry_params.svh
// constants for the output telemetry readout block
`ifndef TELEMETRY_PARAMS_SVH
`define TELEMETRY_PARAMS_SVH
`define REG_ADDR_VOLT      8'h17
`define REG_ADDR_CURR      8'h18
`define REG_ADDR_POWER     8'h19
`define READING_MSB        15
`define READING_LSB_12     4
`define RANGE_FIELD_HI     7
`define RANGE_FIELD_LO     6
`define RANGE_LOW_SPAN     2'h0
`define RESERVED_NIBBLE    4'h0
`define READ_ZERO          8'h00
`endif

// >>> telemetry_pkg.sv
// types shared by the telemetry readout files
package telemetry_pkg;
    typedef struct packed {
        logic [11:0] volt_code;
        logic [11:0] curr_code;
    } sample_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } read_byte_t;
    typedef enum logic [0:0] {
        BYTE_HIGH = 1'b0,
        BYTE_LOW  = 1'b1
    } byte_phase_t;
endpackage
